// *** design/atca_defs.svh ***
// constants of the transmit cell assembler
// Summary of operation
// - check byte computed and placed fifth, giving 53-byte output cells.
// - header check covers only the first four header bytes.
// - idle cell sent whenever no cell waits at a cell boundary.
// - at each boundary sample cell-available; read header if set, else idle.
// - read strobe drops exactly one clock for the check byte, then resumes.
// - only payload bytes are scrambled; header and check byte pass clear.
// - start-of-cell input with cell-available marks the first incoming byte.
// - read strobe high exactly in cycles consuming a byte; source supplies it.
// - output start-of-cell marks the first byte of every 53-byte cell.
// - cell-sent indication raised when a cell has been transmitted.
// - state advances only in cycles with cycle enable high.
// - active-low reset asynchronously returns everything to initial state.
// - idle cells carry the standard fixed header, check and payload patterns.
// - coset value always added to the computed check byte.
// - payload scrambler is the standard self-synchronizing kind.
`ifndef ATCA_DEFS_SVH
`define ATCA_DEFS_SVH
`define ATCA_POS_FIRST 6'd0
`define ATCA_HDR_LAST 6'd3
`define ATCA_HEC_POS 6'd4
`define ATCA_CELL_LAST 6'd52
`define ATCA_USER_READS 6'h34
`define ATCA_HEC_POLY 8'h07
`define ATCA_HEC_COSET 8'h55
`define ATCA_CRC_INIT 8'h00
`define ATCA_IDLE_HDR 8'h00
`define ATCA_IDLE_HDR3 8'h01
`define ATCA_IDLE_HEC 8'h52
`define ATCA_IDLE_PAY 8'h6a
`define ATCA_SCR_RST 43'h0
`endif

// *** design/atca_pkg.sv ***
// types shared by the transmit cell assembler
`default_nettype none
package atca_pkg;
	typedef enum logic {
		atca_idle_cell,
		atca_user_cell
	} atca_mode_e;
	typedef logic [5:0] atca_pos_t;
	typedef logic [42:0] atca_scr_t;
	typedef struct packed {
		logic soc;
		logic [7:0] data;
	} atca_byte_s;
	typedef struct packed {
		atca_scr_t hist;
		logic [7:0] data;
	} atca_scr_s;
endpackage
`default_nettype wire

// *** design/atca_tx_cell_assembler.sv ***
// transmit cell assembler: check byte insertion, payload scrambling, idle fill
`include "atca_defs.svh"
`default_nettype none
module atca_tx_cell_assembler
	import atca_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst_n,
	input wire logic cyc_en,
	input wire atca_byte_s cell_in,
	input wire logic cell_avail_in,
	output var logic rd_strobe,
	output var atca_byte_s cell_out,
	output var logic cell_sent
);

	// ==========================================
	// arithmetic
	// ==========================================

	function automatic logic [7:0] crc8_step(
		input logic [7:0] crc,
		input logic [7:0] d
	);
		logic [7:0] c;
		logic fb;
		c = crc;
		for (int i = 7; i >= 0; i--) begin
			fb = c[7] ^ d[i];
			c = {c[6:0], 1'b0};
			if (fb) begin
				c = c ^ `ATCA_HEC_POLY;
			end
		end
		return c;
	endfunction

	// self-synchronizing: each sent bit is the data bit xor the bit sent
	// 43 bit times earlier, msb first
	function automatic atca_scr_s scr_step(
		input atca_scr_t hist,
		input logic [7:0] d
	);
		atca_scr_s r;
		logic s;
		r.hist = hist;
		r.data = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			s = d[i] ^ r.hist[42];
			r.data[i] = s;
			r.hist = {r.hist[41:0], s};
		end
		return r;
	endfunction

	// ==========================================
	// state
	// ==========================================

	atca_pos_t pos_r;
	atca_pos_t pos_nxt;
	atca_mode_e mode_r;
	atca_mode_e mode_nxt;
	logic rd_r;
	logic rd_nxt;
	logic [7:0] crc_r;
	logic [7:0] crc_nxt;
	atca_scr_t scr_r;
	atca_scr_t scr_nxt;
	atca_byte_s out_r;
	atca_byte_s out_nxt;
	logic sent_r;
	logic sent_nxt;

	logic last_pos;
	logic take_user;
	logic [7:0] src_byte;
	atca_scr_s scr_v;

	assign last_pos = (pos_r == `ATCA_CELL_LAST);
	// a user cell whose first byte lacks the start marker is dropped
	// in favour of an idle cell; the stray byte is consumed, which lets
	// a misaligned source slip back into step one byte per cell
	assign take_user = (mode_r == atca_user_cell) &&
		((pos_r != `ATCA_POS_FIRST) || cell_in.soc);

	// ==========================================
	// next-state logic
	// ==========================================

	always_comb begin
		pos_nxt = pos_r;
		mode_nxt = mode_r;
		rd_nxt = rd_r;
		crc_nxt = crc_r;
		scr_nxt = scr_r;
		out_nxt = out_r;
		sent_nxt = sent_r;
		if (take_user) begin
			src_byte = cell_in.data;
		end else if (pos_r == `ATCA_HDR_LAST) begin
			src_byte = `ATCA_IDLE_HDR3;
		end else if (pos_r < `ATCA_HDR_LAST) begin
			src_byte = `ATCA_IDLE_HDR;
		end else begin
			src_byte = `ATCA_IDLE_PAY;
		end
		scr_v = scr_step(scr_r, src_byte);
		if (cyc_en) begin
			if (last_pos) begin
				pos_nxt = `ATCA_POS_FIRST;
			end else begin
				pos_nxt = 6'(pos_r + 6'd1);
			end
			if (last_pos) begin
				// boundary decision: user cell or idle fill
				mode_nxt = cell_avail_in ? atca_user_cell : atca_idle_cell;
			end else if (!take_user) begin
				mode_nxt = atca_idle_cell;
			end
			if (pos_r <= `ATCA_HDR_LAST) begin
				// header bytes pass clear and feed the check
				out_nxt.data = src_byte;
				if (pos_r == `ATCA_POS_FIRST) begin
					crc_nxt = crc8_step(`ATCA_CRC_INIT, src_byte);
				end else begin
					crc_nxt = crc8_step(crc_r, src_byte);
				end
			end else if (pos_r == `ATCA_HEC_POS) begin
				out_nxt.data = crc_r ^ `ATCA_HEC_COSET;
			end else begin
				// scrambler runs only over payload, across cells
				out_nxt.data = scr_v.data;
				scr_nxt = scr_v.hist;
			end
			out_nxt.soc = (pos_r == `ATCA_POS_FIRST);
			sent_nxt = last_pos;
			// strobe for the coming cycle: low in the check slot
			rd_nxt = (mode_nxt == atca_user_cell) &&
				(pos_nxt != `ATCA_HEC_POS);
		end
	end

	// ==========================================
	// registers
	// ==========================================

	always_ff @(posedge ref_clk or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			pos_r <= `ATCA_POS_FIRST;
			mode_r <= atca_idle_cell;
			rd_r <= 1'b0;
			crc_r <= `ATCA_CRC_INIT;
			scr_r <= `ATCA_SCR_RST;
			out_r <= '0;
			sent_r <= 1'b0;
		end else begin
			pos_r <= pos_nxt;
			mode_r <= mode_nxt;
			rd_r <= rd_nxt;
			crc_r <= crc_nxt;
			scr_r <= scr_nxt;
			out_r <= out_nxt;
			sent_r <= sent_nxt;
		end
	end

	assign rd_strobe = rd_r;
	assign cell_out = out_r;
	assign cell_sent = sent_r;

	// ==========================================
	// read count check
	// ==========================================

	// bytes taken so far in this cell, only there to bound the read count
	logic [5:0] rd_cnt_r;
	logic [5:0] rd_cnt_nxt;

	always_comb begin
		rd_cnt_nxt = rd_cnt_r;
		if (cyc_en) begin
			if (last_pos) begin
				rd_cnt_nxt = 6'h00;
			end else if (rd_r) begin
				rd_cnt_nxt = 6'(rd_cnt_r + 6'h01);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			rd_cnt_r <= 6'h00;
		end else begin
			rd_cnt_r <= rd_cnt_nxt;
		end
	end

	// ==========================================
	// assertions
	// ==========================================

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!sys_rst_n);

	sequence s_hdr_end;
		cyc_en && rd_r && pos_r == `ATCA_HDR_LAST;
	endsequence

	sequence s_hec_slot;
		cyc_en && pos_r == `ATCA_HEC_POS;
	endsequence

	sequence s_boundary;
		cyc_en && last_pos;
	endsequence

	sequence s_user_hec;
		s_hec_slot ##0 mode_r == atca_user_cell;
	endsequence

	sequence s_sent_out;
		cyc_en && cell_sent;
	endsequence

	sequence s_no_soc;
		cyc_en && mode_r == atca_user_cell && pos_r == `ATCA_POS_FIRST && !cell_in.soc;
	endsequence

	// strobe drops for the check slot, then comes back
	a_hec_strobe_gap: assert property (
		s_hdr_end |=> !rd_strobe)
		else $error("strobe not dropped for the check slot");

	a_hec_strobe_back: assert property (
		s_user_hec |=> rd_strobe)
		else $error("strobe not resumed after the check slot");

	a_strobe_only_user: assert property (
		rd_strobe |-> mode_r == atca_user_cell && pos_r != `ATCA_HEC_POS)
		else $error("strobe high outside a user byte");

	a_boundary_pick: assert property (
		s_boundary |=> (rd_strobe == $past(cell_avail_in)) &&
			pos_r == `ATCA_POS_FIRST)
		else $error("boundary did not follow cell available");

	a_check_byte: assert property (
		s_hec_slot |=> cell_out.data == ($past(crc_r) ^ `ATCA_HEC_COSET))
		else $error("check byte lacks coset");

	a_idle_check: assert property (
		s_hec_slot ##0 mode_r == atca_idle_cell |=>
			cell_out.data == `ATCA_IDLE_HEC)
		else $error("idle cell check byte wrong");

	a_hdr_clear: assert property (
		cyc_en && take_user && pos_r <= `ATCA_HDR_LAST |=>
			cell_out.data == $past(cell_in.data))
		else $error("header byte altered");

	a_soc_first: assert property (
		cyc_en |=> cell_out.soc == ($past(pos_r) == `ATCA_POS_FIRST))
		else $error("output start marker misplaced");

	a_sent_pulse: assert property (
		s_boundary |=> cell_sent)
		else $error("cell sent missing after last byte");

	a_sent_single: assert property (
		s_sent_out |=> !cell_sent)
		else $error("cell sent not a single pulse");

	a_sent_first: assert property (
		cell_sent |-> pos_r == `ATCA_POS_FIRST)
		else $error("cell sent away from cell end");

	a_hold_state: assert property (
		!cyc_en |=> $stable(pos_r) && $stable(cell_out) &&
			$stable(rd_strobe) && $stable(cell_sent))
		else $error("state moved without cycle enable");

	a_cell_len: assert property (
		cyc_en && pos_r == `ATCA_POS_FIRST |=>
			pos_r == 6'd1 && !cell_sent)
		else $error("cell length count broken");

	a_read_count: assert property (
		s_boundary ##0 mode_r == atca_user_cell |->
			rd_r && (6'(rd_cnt_r + 6'h01) == `ATCA_USER_READS))
		else $error("user cell read count wrong");

	a_pos_range: assert property (
		pos_r <= `ATCA_CELL_LAST)
		else $error("cell position out of range");

	a_scr_header: assert property (
		cyc_en && pos_r <= `ATCA_HEC_POS |=> $stable(scr_r))
		else $error("scrambler moved outside payload");

	a_refuse_idle: assert property (
		s_no_soc |=> mode_r == atca_idle_cell && !rd_strobe)
		else $error("cell without start marker not refused");

	a_idle_stays: assert property (
		cyc_en && !last_pos && mode_r == atca_idle_cell |=> mode_r == atca_idle_cell)
		else $error("idle cell turned into user cell");

endmodule
`default_nettype wire

// *** sim/atca_cell_src.sv ***
// upstream cell source model feeding the transmit cell assembler
`default_nettype none
module atca_cell_src
	import atca_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst_n,
	input wire logic cyc_en,
	input wire logic rd_strobe,
	input wire logic [3:0] add,
	input wire logic no_soc,
	output var atca_byte_s cell_in,
	output var logic cell_avail_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// cell numbering survives a device reset so the bench can track order
	logic [7:0] k = 8'h00;
	logic [7:0] noise;
	logic [5:0] pos;
	logic [3:0] pend;
	logic done;
	// ================================
	// cell presentation
	// a cell being read does not count as the next one ready
	assign cell_avail_in = (pos == 6'h00) ? (pend != 4'h0) : (pend > 4'h1);
	assign done = cyc_en && rd_strobe && pos == 6'h33;
	always_comb begin
		cell_in.soc = pend != 4'h0 && pos == 6'h00 && !no_soc;
		if (pend == 4'h0) begin
			cell_in.data = noise;
		end else begin
			case (pos)
				6'h00: cell_in.data = k + 8'h01;
				6'h01: cell_in.data = 8'h5a;
				6'h02: cell_in.data = 8'hc3;
				6'h03: cell_in.data = k;
				default: cell_in.data = k ^ {2'h0, pos};
			endcase
		end
	end
	always @(posedge ref_clk or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			pos <= 6'h00;
			pend <= 4'h0;
			noise <= 8'h00;
		end else begin
			noise <= noise + 8'h3b;
			pend <= pend + add - {3'h0, done};
			if (cyc_en && rd_strobe) begin
				pos <= done ? 6'h00 : pos + 6'h01;
				if (done) k <= k + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// *** sim/atm_tx_cell_assembler_tb_top.sv ***
// self-checking bench for the transmit cell assembler
`include "atca_defs.svh"
`default_nettype none
module atm_tx_cell_assembler_tb_top
	import atca_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic sys_rst_n = 1'b0;
	logic cyc_en = 1'b1;
	logic en_d = 1'b0;
	logic sync = 1'b0;
	logic [3:0] add = 4'h0;
	logic no_soc = 1'b0;
	atca_byte_s cell_in, cell_out;
	logic cell_avail_in, rd_strobe, cell_sent;
	int fails = 0, comparisons = 0, cycles = 0, nstb = 0, ncell = 0, ucnt = 0;
	logic [5:0] pos = 6'h00;
	logic [7:0] b, p, crc;
	logic [7:0] cb [0:63];
	atca_scr_t hist;
	always #20 ref_clk = ~ref_clk;
	atca_tx_cell_assembler uut (.ref_clk(ref_clk), .sys_rst_n(sys_rst_n), .cyc_en(cyc_en),
		.cell_in(cell_in), .cell_avail_in(cell_avail_in), .rd_strobe(rd_strobe),
		.cell_out(cell_out), .cell_sent(cell_sent));
	atca_cell_src src (.ref_clk(ref_clk), .sys_rst_n(sys_rst_n), .cyc_en(cyc_en),
		.rd_strobe(rd_strobe), .add(add), .no_soc(no_soc), .cell_in(cell_in),
		.cell_avail_in(cell_avail_in));
	// ================================
	// checking and closing
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check_cell;
		crc = 8'h00;
		for (int i = 0; i < 4; i++) for (int j = 7; j >= 0; j--)
			crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ cb[i][j]) ? 8'h07 : 8'h00);
		chk(cb[4], crc ^ 8'h55);
		ncell++;
		if (cb[0] == 8'h00) begin
			chk(cb[1] | cb[2], `ATCA_IDLE_HDR);
			chk(cb[3], `ATCA_IDLE_HDR3);
			for (int i = 5; i < 53; i++) chk(cb[i], `ATCA_IDLE_PAY);
		end else begin
			chk(cb[0], ucnt[7:0] + 8'h01);
			chk(cb[1] ^ cb[2], 8'h99);
			chk(cb[3], ucnt[7:0]);
			for (int i = 5; i < 53; i++) chk(cb[i], ucnt[7:0] ^ (i[7:0] - 8'h01));
			ucnt++;
		end
	endtask
	// ================================
	// output monitor, descrambles payload with its own history
	always @(posedge ref_clk) begin
		en_d <= cyc_en & sys_rst_n;
		if (cyc_en && rd_strobe) nstb++;
		cycles++;
		if (cycles == 2000) begin
			fails++;
			stop_test;
		end
	end
	always @(negedge ref_clk) begin
		if (!sys_rst_n) begin
			sync = 1'b0;
			hist = '0;
		end else if (en_d) begin
			if (cell_out.soc) begin
				if (sync) chk({2'h0, pos}, 8'h34);
				pos = 6'h00;
				sync = 1'b1;
			end else pos++;
			if (sync) begin
				chk({7'h0, cell_sent}, {7'h0, pos == 6'h34});
				b = cell_out.data;
				p = b;
				if (pos > 6'h04) for (int j = 7; j >= 0; j--) begin
					p[j] = b[j] ^ hist[42];
					hist = {hist[41:0], b[j]};
				end
				cb[pos] = p;
				if (pos == 6'h34) check_cell;
			end
		end
	end
	// ================================
	// scenarios
	task automatic t_idle;
		repeat (170) @(posedge ref_clk);
		chk({7'h0, ncell >= 2}, 8'h01);
		chk(nstb[7:0], 8'h00);
	endtask
	task automatic t_user;
		add <= 4'h3;
		@(posedge ref_clk);
		add <= 4'h0;
		repeat (260) @(posedge ref_clk);
		chk(ucnt[7:0], 8'h03);
		chk(nstb[7:0], 8'h9c);
	endtask
	task automatic t_enable;
		logic [10:0] o;
		add <= 4'h1;
		@(posedge ref_clk);
		add <= 4'h0;
		repeat (80) @(posedge ref_clk);
		cyc_en <= 1'b0;
		@(negedge ref_clk);
		o = {cell_out, cell_sent, rd_strobe};
		repeat (10) @(negedge ref_clk);
		chk({7'h0, o === {cell_out, cell_sent, rd_strobe}}, 8'h01);
		@(posedge ref_clk);
		cyc_en <= 1'b1;
		repeat (120) @(posedge ref_clk);
		chk(ucnt[7:0], 8'h04);
		chk(nstb[7:0], 8'hd0);
	endtask
	// a cell offered without its start marker: one byte taken, idle cell sent
	task automatic t_refuse;
		no_soc <= 1'b1;
		add <= 4'h1;
		@(posedge ref_clk);
		add <= 4'h0;
		repeat (110) @(posedge ref_clk);
		no_soc <= 1'b0;
		chk(nstb[7:0], 8'hd1);
		chk(ucnt[7:0], 8'h04);
	endtask
	task automatic t_reset;
		repeat (30) @(posedge ref_clk);
		sys_rst_n <= 1'b0;
		@(negedge ref_clk);
		chk(cell_out.data | {7'h0, cell_out.soc | cell_sent | rd_strobe}, 8'h00);
		repeat (5) @(posedge ref_clk);
		sys_rst_n <= 1'b1;
		@(posedge ref_clk);
		add <= 4'h1;
		@(posedge ref_clk);
		add <= 4'h0;
		repeat (180) @(posedge ref_clk);
		chk(ucnt[7:0], 8'h05);
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		sys_rst_n <= 1'b1;
		t_idle;
		t_user;
		t_enable;
		t_refuse;
		t_reset;
		stop_test;
	end
endmodule
`default_nettype wire
